// *** common/mspc_params.svh ***
// constants of the three-submodule pulse-width modulator
// assumes a single 10 MHz clock and a plain strobe register port
// Function
// - Setting a run bit enables that submodule's counter; several start together.
// - Clearing a run bit stops the submodule and resets its counter.
// - Three independent submodules 0..2; submodule 0 acts as master.
// - Each submodule drives outputs A, B and auxiliary X.
// - Six compare values per submodule, selectable singly or several at once by bit mask.
// - Counter clock from bus clock, external clock, or submodule 0 auxiliary clock.
// - Prescaler divides selected clock by 1 to 128 in eight power-of-two steps.
// - Local force source: software force bit in second control register forces update.
// - Master force source: submodule 0 force signal forces update.
// - Local reload source: own reload forces update regardless of load-ok bit.
// - Master reload source: submodule 0 reload forces update only with load-ok set.
// - Force trigger may be local sync or master sync from submodule 0.
// - Force trigger may be external force or external sync input.
// - Each output: forced high, forced low, normal, inverted, or masked.
// - Interrupt enables set and cleared by mask and readable back.
// - Status flags readable; selected flags clearable by software mask.
// - Capture DMA read request enabled when any bit of the six-bit capture enable mask is set.
// - One control enables the DMA write request for buffered registers.
// - Capture DMA source select and watermark combine control per submodule.
// - Period count is 16 bits, 0 to 65535.
// - Duty 0 means always inactive, 65535 always active, linear between.
// - Watermark conditions combined by OR or by AND for DMA request.
// - Capture DMA from watermark, local sync, local reload, or disabled.
// - Immediate reload loads on load-ok; else half, full, or both cycles.
`ifndef MSPC_PARAMS_SVH
`define MSPC_PARAMS_SVH
// ----------------------------------------
// register map: address = {sub[1:0], reg[3:0]}, sub 3 = global
// ----------------------------------------
`define MSPC_AW          6
`define MSPC_SUB_GLOBAL  2'h3
`define MSPC_R_RUN       4'h0
`define MSPC_R_LOAD_OK   4'h1
`define MSPC_R_CTRL      4'h0
`define MSPC_R_FORCE     4'h1
`define MSPC_R_PERIOD    4'h2
`define MSPC_R_VAL       4'h3
`define MSPC_R_VALSEL    4'h4
`define MSPC_R_OUTSTATE  4'h5
`define MSPC_R_INTEN_SET 4'h6
`define MSPC_R_INTEN_CLR 4'h7
`define MSPC_R_STATUS    4'h8
`define MSPC_R_DMA       4'h9
`define MSPC_R_COUNT     4'hA
// ----------------------------------------
// fields
// ----------------------------------------
`define MSPC_CTRL_CLK    1:0
`define MSPC_CTRL_PRE    4:2
`define MSPC_CTRL_FSEL   7:5
`define MSPC_CTRL_RELD   9:8
`define MSPC_FORCE_BIT   0
`define MSPC_DMA_CAPEN   5:0
`define MSPC_DMA_WREN    6
`define MSPC_DMA_SRC     8:7
`define MSPC_DMA_AND     9
`define MSPC_ST_RELOAD   6
`define MSPC_ST_SYNC     7
`define MSPC_NFLAG       8
`define MSPC_NVAL        6
`define MSPC_PERIOD_RST  16'hFFFF
`endif

// *** common/mspc_pkg.sv ***
// types of the three-submodule modulator
// assumes mspc_params.svh holds the numeric constants
package mspc_pkg;
    typedef enum logic [1:0] {
        MSPC_CLK_BUS = 2'h0,
        MSPC_CLK_EXT = 2'h1,
        MSPC_CLK_AUX = 2'h2
    } mspc_clk_e;
    typedef enum logic [2:0] {
        MSPC_F_LOCAL    = 3'h0,
        MSPC_F_MASTER   = 3'h1,
        MSPC_F_LRELOAD  = 3'h2,
        MSPC_F_MRELOAD  = 3'h3,
        MSPC_F_LSYNC    = 3'h4,
        MSPC_F_MSYNC    = 3'h5,
        MSPC_F_EXTFORCE = 3'h6,
        MSPC_F_EXTSYNC  = 3'h7
    } mspc_force_e;
    typedef enum logic [2:0] {
        MSPC_O_HIGH   = 3'h0,
        MSPC_O_LOW    = 3'h1,
        MSPC_O_NORMAL = 3'h2,
        MSPC_O_INVERT = 3'h3,
        MSPC_O_MASK   = 3'h4
    } mspc_ostate_e;
    typedef enum logic [1:0] {
        MSPC_RL_IMMED = 2'h0,
        MSPC_RL_HALF  = 2'h1,
        MSPC_RL_FULL  = 2'h2,
        MSPC_RL_BOTH  = 2'h3
    } mspc_reload_e;
    typedef enum logic [1:0] {
        MSPC_DS_OFF  = 2'h0,
        MSPC_DS_WM   = 2'h1,
        MSPC_DS_SYNC = 2'h2,
        MSPC_DS_RELD = 2'h3
    } mspc_dsrc_e;
    typedef enum logic [1:0] {
        MSPC_ST_IDLE = 2'b01,
        MSPC_ST_RUN  = 2'b10
    } mspc_run_e;
endpackage

// *** hdl/mspc_top.sv ***
// three-submodule pulse-width modulator with strobe register port
// assumes external pins asynchronous; capture FIFO watermarks come from outside
//
// The implementer's own choices: the address-and-strobe port and the address map.
`include "mspc_params.svh"
module mspc_top #(
    parameter int NSUB = 3,
    parameter int CW   = 16
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    // register port
    input  wire logic [`MSPC_AW-1:0]   addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [31:0]           rdata_o,
    // external pins
    input  wire logic                  external_clock_in_i,
    input  wire logic                  external_force_in_i,
    input  wire logic                  external_sync_in_i,
    input  wire logic [NSUB*2-1:0]     capture_watermark_i,
    // outputs
    output logic      [NSUB-1:0]       primary_output_a_o,
    output logic      [NSUB-1:0]       primary_output_b_o,
    output logic      [NSUB-1:0]       auxiliary_output_x_o,
    output logic      [NSUB-1:0]       irq_pending_o,
    output logic      [NSUB-1:0]       dma_read_req_o,
    output logic      [NSUB-1:0]       dma_write_req_o
);
    import mspc_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic edge_pick(input logic [1:0] sel, input logic bus,
                                       input logic ext, input logic aux);
        case (sel)
            MSPC_CLK_BUS: edge_pick = bus;
            MSPC_CLK_EXT: edge_pick = ext;
            MSPC_CLK_AUX: edge_pick = aux;
            default:      edge_pick = 1'b0;
        endcase
    endfunction

    function automatic logic out_shape(input logic [2:0] st, input logic wave);
        case (st)
            MSPC_O_HIGH:   out_shape = 1'b1;
            MSPC_O_LOW:    out_shape = 1'b0;
            MSPC_O_NORMAL: out_shape = wave;
            MSPC_O_INVERT: out_shape = ~wave;
            default:       out_shape = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic       xclk_d;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pin_s1    <= 3'h0;
            pin_s2    <= 3'h0;
            xclk_d    <= 1'b0;
        end else begin
            pin_s1    <= {external_sync_in_i, external_force_in_i, external_clock_in_i};
            pin_s2    <= pin_s1;
            xclk_d    <= pin_s2[0];
        end
    end
    logic xclk_rise;
    assign xclk_rise = pin_s2[0] & ~xclk_d;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic [1:0] a_sub;
    logic [3:0] a_reg;
    logic       glb_wr;
    assign a_sub  = addr_i[5:4];
    assign a_reg  = addr_i[3:0];
    assign glb_wr = wr_i && (a_sub == `MSPC_SUB_GLOBAL);

    logic [NSUB-1:0] run_bits;
    logic [NSUB-1:0] load_ok_bit;
    logic [NSUB-1:0] reload_evt;
    mspc_run_e       run_st [NSUB];

    // one write starts or stops any set of submodules
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            run_bits <= '0;
        end else if (glb_wr && a_reg == `MSPC_R_RUN) begin
            run_bits <= wdata_i[NSUB-1:0];
        end
    end

    // load-ok set by software, cleared by the reload it enables
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            load_ok_bit <= '0;
        end else begin
            for (int s = 0; s < NSUB; s++) begin
                if (glb_wr && a_reg == `MSPC_R_LOAD_OK && wdata_i[s]) begin
                    load_ok_bit[s] <= 1'b1;
                end else if (reload_evt[s]) begin
                    load_ok_bit[s] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // per-submodule state
    // ----------------------------------------
    logic [9:0]        ctrl     [NSUB];
    logic              force_sw [NSUB];
    logic [CW-1:0]     period_b [NSUB];
    logic [CW-1:0]     period   [NSUB];
    logic [CW-1:0]     val_b    [NSUB][`MSPC_NVAL];
    logic [CW-1:0]     val      [NSUB][`MSPC_NVAL];
    logic [5:0]        val_sel  [NSUB];
    logic [8:0]        ostate_b [NSUB];
    logic [8:0]        ostate   [NSUB];
    logic [`MSPC_NFLAG-1:0] inten  [NSUB];
    logic [`MSPC_NFLAG-1:0] status [NSUB];
    logic [9:0]        dmactl   [NSUB];
    logic [CW-1:0]     count    [NSUB];
    logic [6:0]        pre_cnt  [NSUB];
    logic [NSUB-1:0]   tick;
    logic [NSUB-1:0]   aux_clk;
    logic [NSUB-1:0]   lsync;
    logic [NSUB-1:0]   half_pt;
    logic [NSUB-1:0]   force_evt;
    logic [NSUB-1:0]   wave_a;
    logic [NSUB-1:0]   wave_b;
    logic [NSUB-1:0]   wave_x;

    for (genvar s = 0; s < NSUB; s++) begin : g_sub
        logic sw;
        logic src_edge;
        logic [7:0] pre_mask;
        logic [`MSPC_NFLAG-1:0] flag_set;
        logic reload_ok;
        logic wm_hit;
        assign sw = wr_i && (a_sub == 2'(s));

        // control registers
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                ctrl[s]     <= '0;
                period_b[s] <= `MSPC_PERIOD_RST;
                val_sel[s]  <= 6'h01;
                ostate_b[s] <= {3{MSPC_O_NORMAL}};
                dmactl[s]   <= '0;
                for (int v = 0; v < `MSPC_NVAL; v++) val_b[s][v] <= '0;
            end else if (sw) begin
                case (a_reg)
                    `MSPC_R_CTRL:     ctrl[s]     <= wdata_i[9:0];
                    `MSPC_R_PERIOD:   period_b[s] <= wdata_i[CW-1:0];
                    `MSPC_R_VALSEL:   val_sel[s]  <= wdata_i[5:0];
                    `MSPC_R_OUTSTATE: ostate_b[s] <= wdata_i[8:0];
                    `MSPC_R_DMA:      dmactl[s]   <= wdata_i[9:0];
                    `MSPC_R_VAL: begin
                        for (int v = 0; v < `MSPC_NVAL; v++)
                            if (val_sel[s][v]) val_b[s][v] <= wdata_i[CW-1:0];
                    end
                    default: ;
                endcase
            end
        end

        // software force pulse, self-clearing
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) force_sw[s] <= 1'b0;
            else force_sw[s] <= sw && a_reg == `MSPC_R_FORCE && wdata_i[`MSPC_FORCE_BIT];
        end

        // interrupt enable set/clear by mask
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                inten[s] <= '0;
            end else if (sw && a_reg == `MSPC_R_INTEN_SET) begin
                inten[s] <= inten[s] | wdata_i[`MSPC_NFLAG-1:0];
            end else if (sw && a_reg == `MSPC_R_INTEN_CLR) begin
                inten[s] <= inten[s] & ~wdata_i[`MSPC_NFLAG-1:0];
            end
        end

        // clock source and prescaler
        assign src_edge = edge_pick(ctrl[s][`MSPC_CTRL_CLK], 1'b1, xclk_rise,
                                    aux_clk[0]);
        assign pre_mask = 8'((1 << ctrl[s][`MSPC_CTRL_PRE]) - 1);
        always_ff @(posedge clk_i) begin
            if (!rst_b_i || run_st[s] == MSPC_ST_IDLE) begin
                pre_cnt[s] <= '0;
            end else if (src_edge) begin
                pre_cnt[s] <= (pre_cnt[s] & pre_mask[6:0]) == pre_mask[6:0]
                              ? 7'h0 : pre_cnt[s] + 7'h1;
            end
        end
        assign tick[s] = run_st[s] == MSPC_ST_RUN && src_edge &&
                         (pre_cnt[s] & pre_mask[6:0]) == pre_mask[6:0];
        assign aux_clk[s] = tick[s];

        // run state machine
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                run_st[s] <= MSPC_ST_IDLE;
            end else begin
                case (run_st[s])
                    MSPC_ST_IDLE: if (run_bits[s]) run_st[s] <= MSPC_ST_RUN;
                    MSPC_ST_RUN:  if (!run_bits[s]) run_st[s] <= MSPC_ST_IDLE;
                    default:      run_st[s] <= MSPC_ST_IDLE;
                endcase
            end
        end

        // counter
        always_ff @(posedge clk_i) begin
            if (!rst_b_i || !run_bits[s]) begin
                count[s] <= '0;
            end else if (tick[s]) begin
                count[s] <= count[s] >= period[s] ? '0 : count[s] + 1'b1;
            end
        end
        assign lsync[s]   = tick[s] && count[s] == val[s][1];
        assign half_pt[s] = tick[s] && count[s] == (period[s] >> 1);

        // reload timing
        always_comb begin
            case (ctrl[s][`MSPC_CTRL_RELD])
                MSPC_RL_IMMED: reload_ok = 1'b1;
                MSPC_RL_HALF:  reload_ok = half_pt[s];
                MSPC_RL_FULL:  reload_ok = tick[s] && count[s] >= period[s];
                default:       reload_ok = half_pt[s] ||
                                           (tick[s] && count[s] >= period[s]);
            endcase
        end
        assign reload_evt[s] = load_ok_bit[s] && reload_ok;

        // force source select
        always_comb begin
            case (ctrl[s][`MSPC_CTRL_FSEL])
                MSPC_F_LOCAL:    force_evt[s] = force_sw[s];
                MSPC_F_MASTER:   force_evt[s] = force_sw[0];
                MSPC_F_LRELOAD:  force_evt[s] = reload_ok && tick[s];
                MSPC_F_MRELOAD:  force_evt[s] = reload_evt[0];
                MSPC_F_LSYNC:    force_evt[s] = lsync[s];
                MSPC_F_MSYNC:    force_evt[s] = lsync[0];
                MSPC_F_EXTFORCE: force_evt[s] = pin_s2[1];
                default:         force_evt[s] = pin_s2[2];
            endcase
        end

        // buffered values
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                period[s] <= `MSPC_PERIOD_RST;
                for (int v = 0; v < `MSPC_NVAL; v++) val[s][v] <= '0;
            end else if (reload_evt[s]) begin
                period[s] <= period_b[s];
                for (int v = 0; v < `MSPC_NVAL; v++) val[s][v] <= val_b[s][v];
            end
        end
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) ostate[s] <= {3{MSPC_O_NORMAL}};
            else if (force_evt[s]) ostate[s] <= ostate_b[s];
        end

        // waveform: high while count below duty (0 never, full always)
        assign wave_a[s] = val[s][3] == '1 || count[s] < val[s][3];
        assign wave_b[s] = val[s][5] == '1 || count[s] < val[s][5];
        assign wave_x[s] = val[s][2] == '1 || count[s] < val[s][2];

        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                primary_output_a_o[s]   <= 1'b0;
                primary_output_b_o[s]   <= 1'b0;
                auxiliary_output_x_o[s] <= 1'b0;
            end else begin
                primary_output_a_o[s]   <= out_shape(ostate[s][2:0], wave_a[s]);
                primary_output_b_o[s]   <= out_shape(ostate[s][5:3], wave_b[s]);
                auxiliary_output_x_o[s] <= out_shape(ostate[s][8:6], wave_x[s]);
            end
        end

        // status flags: compare hits, reload, sync
        always_comb begin
            flag_set = '0;
            for (int v = 0; v < `MSPC_NVAL; v++)
                flag_set[v] = tick[s] && count[s] == val[s][v];
            flag_set[`MSPC_ST_RELOAD] = reload_evt[s];
            flag_set[`MSPC_ST_SYNC]   = lsync[s];
        end
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                status[s] <= '0;
            end else if (sw && a_reg == `MSPC_R_STATUS) begin
                status[s] <= (status[s] & ~wdata_i[`MSPC_NFLAG-1:0]) | flag_set;
            end else begin
                status[s] <= status[s] | flag_set;
            end
        end
        assign irq_pending_o[s] = |(status[s] & inten[s]);

        // dma requests
        assign wm_hit = dmactl[s][`MSPC_DMA_AND]
                        ? &capture_watermark_i[2*s +: 2]
                        : |capture_watermark_i[2*s +: 2];
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                dma_read_req_o[s] <= 1'b0;
            end else begin
                case (dmactl[s][`MSPC_DMA_SRC])
                    MSPC_DS_WM:   dma_read_req_o[s] <= wm_hit && |dmactl[s][`MSPC_DMA_CAPEN];
                    MSPC_DS_SYNC: dma_read_req_o[s] <= lsync[s] && |dmactl[s][`MSPC_DMA_CAPEN];
                    MSPC_DS_RELD: dma_read_req_o[s] <= reload_evt[s] &&
                                                      |dmactl[s][`MSPC_DMA_CAPEN];
                    default:      dma_read_req_o[s] <= 1'b0;
                endcase
            end
        end
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) dma_write_req_o[s] <= 1'b0;
            else dma_write_req_o[s] <= dmactl[s][`MSPC_DMA_WREN] && !load_ok_bit[s];
        end

        // assertions
        a_stop_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            !run_bits[s] |=> count[s] == '0)
            else $error("counter not reset while stopped");
        a_load_ok_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            reload_evt[s] |=> period[s] == $past(period_b[s]))
            else $error("period not reloaded");
        a_flag_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            reload_evt[s] |=> status[s][`MSPC_ST_RELOAD])
            else $error("reload flag lost");
        a_mask_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            inten[s] == '0 |-> !irq_pending_o[s])
            else $error("masked interrupt raised");
        a_force_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            ostate[s][2:0] == MSPC_O_HIGH |=> primary_output_a_o[s])
            else $error("forced high not high");
        a_force_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            ostate[s][5:3] == MSPC_O_LOW |=> !primary_output_b_o[s])
            else $error("forced low not low");
        a_idle_tick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            run_st[s] == MSPC_ST_IDLE |-> !tick[s])
            else $error("tick while idle");
        a_wr_dma: assert property (@(posedge clk_i) disable iff (!rst_b_i)
            !dmactl[s][`MSPC_DMA_WREN] |=> !dma_write_req_o[s])
            else $error("write request while disabled");
    end

    // ----------------------------------------
    // read data, one cycle after strobe
    // ----------------------------------------
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0;
        if (a_sub == `MSPC_SUB_GLOBAL) begin
            case (a_reg)
                `MSPC_R_RUN:  next_rdata = 32'(run_bits);
                `MSPC_R_LOAD_OK: next_rdata = 32'(load_ok_bit);
                default:      next_rdata = 32'h0;
            endcase
        end else if (a_sub < 2'(NSUB)) begin
            case (a_reg)
                `MSPC_R_CTRL:     next_rdata = 32'(ctrl[a_sub]);
                `MSPC_R_PERIOD:   next_rdata = 32'(period_b[a_sub]);
                `MSPC_R_VALSEL:   next_rdata = 32'(val_sel[a_sub]);
                `MSPC_R_OUTSTATE: next_rdata = 32'(ostate_b[a_sub]);
                `MSPC_R_INTEN_SET,
                `MSPC_R_INTEN_CLR: next_rdata = 32'(inten[a_sub]);
                `MSPC_R_STATUS:   next_rdata = 32'(status[a_sub]);
                `MSPC_R_DMA:      next_rdata = 32'(dmactl[a_sub]);
                `MSPC_R_COUNT:    next_rdata = 32'(count[a_sub]);
                `MSPC_R_VAL: begin
                    for (int v = `MSPC_NVAL - 1; v >= 0; v--)
                        if (val_sel[a_sub][v]) next_rdata = 32'(val_b[a_sub][v]);
                end
                default:          next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) rdata_o <= 32'h0;
        else if (rd_i) rdata_o <= next_rdata;
        else rdata_o <= 32'h0;
    end
endmodule

// *** bench/mspc_load.sv ***
// load-side stand-in: drives the outside force, sync, clock and watermark pins
// assumes bench commands arrive on the modulator clock
module mspc_load (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // bench commands
    input  wire logic       fire_i,
    input  wire logic [5:0] wm_i,
    // pins into the modulator
    output logic            xclk_o,
    output logic            xforce_o,
    output logic            xsync_o,
    output logic [5:0]      wm_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] hold;
    assign xforce_o = (hold != 2'h0);
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            hold       <= 2'h0;
            xclk_o     <= 1'b0;
            xsync_o    <= 1'b0;
            wm_o       <= 6'h00;
        end else begin
            // force held three cycles so the pin synchronizer sees it
            hold       <= fire_i ? 2'h3 : hold - {1'b0, hold != 2'h0};
            xclk_o     <= ~xclk_o;
            xsync_o    <= 1'b0;
            wm_o       <= wm_i;
        end
    end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the three-submodule modulator
// assumes mspc_top, mspc_load and mspc_params.svh on the include path
`include "mspc_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mspc_pkg::*;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, fire = 1'b0;
    logic [5:0]  addr_i = 6'h00, wm_cmd = 6'h00, wm;
    logic [31:0] wdata_i = 32'h0, rdata_o, rv;
    logic [2:0]  a, b, x, irq, dmar, dmaw;
    logic        eclk, eforce, esync;
    int          failures = 0, n_checks = 0;
    mspc_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_clock_in_i(eclk),
        .external_force_in_i(eforce), .external_sync_in_i(esync), .capture_watermark_i(wm),
        .primary_output_a_o(a), .primary_output_b_o(b), .auxiliary_output_x_o(x),
        .irq_pending_o(irq), .dma_read_req_o(dmar), .dma_write_req_o(dmaw));
    mspc_load load_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .fire_i(fire), .wm_i(wm_cmd),
        .xclk_o(eclk), .xforce_o(eforce), .xsync_o(esync), .wm_o(wm));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [1:0] s, logic [3:0] r, logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= {s, r};
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rdc(string what, logic [1:0] s, logic [3:0] r, logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= {s, r};
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 rv = rdata_o;
        check(what, rv, exp);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic close_out;
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        close_out();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rdc("period", 2'h0, `MSPC_R_PERIOD, 32'h0000FFFF);
        rdc("valsel", 2'h1, `MSPC_R_VALSEL, 32'h00000001);
        rdc("ostate", 2'h2, `MSPC_R_OUTSTATE, 32'h00000092);
        rdc("unmapped", `MSPC_SUB_GLOBAL, 4'h2, 32'h0);
        wr(2'h0, `MSPC_R_INTEN_SET, 32'h000000C3);
        wr(2'h0, `MSPC_R_INTEN_CLR, 32'h00000041);
        rdc("inten", 2'h0, `MSPC_R_INTEN_CLR, 32'h00000082);
        wr(2'h0, `MSPC_R_DMA, 32'h000002FF);
        rdc("dma", 2'h0, `MSPC_R_DMA, 32'h000002FF);
        check("dma_wr", {31'h0, dmaw[0]}, 32'h1);
        wm_cmd <= 6'h01;
        settle(4);
        check("wm_and_one", {31'h0, dmar[0]}, 32'h0);
        wm_cmd <= 6'h03;
        settle(4);
        check("wm_and_two", {31'h0, dmar[0]}, 32'h1);
        wr(2'h0, `MSPC_R_DMA, 32'h000000FF);
        wm_cmd <= 6'h01;
        settle(4);
        check("wm_or", {31'h0, dmar[0]}, 32'h1);
        wr(`MSPC_SUB_GLOBAL, `MSPC_R_LOAD_OK, 32'h1);
        settle(3);
        rdc("load_ok", `MSPC_SUB_GLOBAL, `MSPC_R_LOAD_OK, 32'h0);
        rdc("reload_flag", 2'h0, `MSPC_R_STATUS, 32'h00000040);
        check("reload_set", {31'h0, rv[`MSPC_ST_RELOAD]}, 32'h1);
        check("irq_masked", {31'h0, irq[0]}, 32'h0);
        wr(2'h0, `MSPC_R_STATUS, 32'h0);
        wr(2'h0, `MSPC_R_INTEN_SET, 32'h00000040);
        rdc("flag_kept", 2'h0, `MSPC_R_STATUS, 32'h00000040);
        check("kept", {31'h0, rv[`MSPC_ST_RELOAD]}, 32'h1);
        check("irq_on", {31'h0, irq[0]}, 32'h1);
        wr(2'h0, `MSPC_R_STATUS, 32'h40);
        rdc("flag_clear", 2'h0, `MSPC_R_STATUS, 32'h00000000);
        check("irq_off", {31'h0, irq[0]}, 32'h0);
        wr(2'h0, `MSPC_R_VALSEL, 32'h00000028);
        wr(2'h0, `MSPC_R_VAL, 32'h0000FFFF);
        wr(`MSPC_SUB_GLOBAL, `MSPC_R_LOAD_OK, 32'h1);
        rdc("val_mask", 2'h0, `MSPC_R_VAL, 32'h0000FFFF);
        check("duty_abx", {29'h0, a[0], b[0], x[0]}, 32'h00000006);
        for (int s = 0; s <= 4; s++) begin
            wr(2'h1, `MSPC_R_OUTSTATE, 32'(s * 73));
            wr(2'h1, `MSPC_R_FORCE, 32'h1);
            settle(4);
            check("ostate_abx", {29'h0, a[1], b[1], x[1]}, {29'h0, {3{s == 0 || s == 3}}});
        end
        wr(2'h2, `MSPC_R_OUTSTATE, 32'h0);
        wr(2'h2, `MSPC_R_CTRL, 32'h000000DC);
        settle(4);
        check("no_force", {31'h0, a[2]}, 32'h0);
        fire <= 1'b1;
        settle(1);
        fire <= 1'b0;
        settle(8);
        check("external_force_in", {31'h0, a[2]}, 32'h1);
        wr(2'h1, `MSPC_R_CTRL, 32'h00000020);
        wr(2'h1, `MSPC_R_OUTSTATE, 32'h0);
        wr(2'h0, `MSPC_R_FORCE, 32'h1);
        settle(4);
        check("master_force", {31'h0, a[1]}, 32'h1);
        wr(`MSPC_SUB_GLOBAL, `MSPC_R_RUN, 32'h7);
        settle(12);
        rdc("count0", 2'h0, `MSPC_R_COUNT, 32'h0000000C);
        check("count0_run", {31'h0, rv[15:0] > 16'h0005}, 32'h1);
        rdc("count1", 2'h1, `MSPC_R_COUNT, 32'h0000000E);
        check("count1_run", {31'h0, rv[15:0] > 16'h0005}, 32'h1);
        rdc("count2", 2'h2, `MSPC_R_COUNT, 32'h00000000);
        check("count2_div", {31'h0, rv[15:0] < 16'h0002}, 32'h1);
        wr(`MSPC_SUB_GLOBAL, `MSPC_R_RUN, 32'h0);
        settle(3);
        rdc("count0_stop", 2'h0, `MSPC_R_COUNT, 32'h0);
        rdc("count1_stop", 2'h1, `MSPC_R_COUNT, 32'h0);
        close_out();
    end
endmodule
